// ---- inc/arrx_pkg.sv ----
package arrx_pkg;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned WRP_W = 5;
   localparam int unsigned SRC_W = 5;
   localparam int unsigned TRD_W = 4;
   localparam int unsigned PKT_W = 8;
   localparam int unsigned FLAG_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BE_W = 4;
   localparam int unsigned ERR_W = 4;
   localparam int unsigned DEPTH = 4;
   localparam int unsigned IDX_W = 2;
   // response codes
   localparam logic [3:0] ERR_OK = 4'h0;
   localparam logic [3:0] ERR_NOINFO = 4'h1;
   localparam logic [3:0] ERR_INCOMPLETE = 4'h9;
   localparam logic [3:0] ERR_RETRY = 4'h5;
   localparam logic [3:0] ERR_UNSUPP = 4'h3;
   localparam logic [3:0] ERR_DEGRADED = 4'hB;
   localparam logic [3:0] ERR_FATAL = 4'h7;
   // predefined pattern: fixed stride in bytes
   localparam logic [31:0] DEFD_STRIDE = 32'h0000_0010;
   // flag bit positions, one per meaning
   localparam int unsigned FLAG_DEGR_RD = 0;
   localparam int unsigned FLAG_DEGR_WR = 1;
   // command codes
   localparam logic [1:0] CMD_NOP = 2'h0;
   localparam logic [1:0] CMD_READ = 2'h1;
   localparam logic [1:0] CMD_WRITE = 2'h2;
   localparam logic [1:0] CMD_LOCKRD = 2'h3;

   typedef struct packed {
      logic [1:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [BE_W-1:0] be;
      logic [DATA_W-1:0] wdata;
      logic wrap;
      logic defd;
      logic wrplen_en;
      logic [WRP_W-1:0] wrplen;
      logic [SRC_W-1:0] srcid;
      logic [TRD_W-1:0] trdid;
      logic [PKT_W-1:0] pktid;
   } arrx_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic [ERR_W-1:0] rerror;
      logic [FLAG_W-1:0] rflag;
      logic [SRC_W-1:0] rsrcid;
      logic [TRD_W-1:0] rtrdid;
      logic [PKT_W-1:0] rpktid;
      logic [ADDR_W-1:0] raddr;
   } arrx_rsp_s;
endpackage

// ---- hdl/arrx_target.sv ----
`timescale 1ns/1ps
// How it works
// - every extension signal is active high unless stated otherwise
// - defined flag means address and enables follow one fixed pattern
// - defined transfer addresses derive from start address and enables only; here start address plus stride, folded by wrap mask
// - exactly one predefined pattern per initiator-target pair
// - wrap boundary comes from wrap length field, not packet length
// - addresses at or above two to wrap length fold modulo that size
// - each initiator has a unique source id; lock owner tracked by it
// - thread id extends source id into logical devices
// - packet id plus source id match responses to requests
// - response extension fields travel with response valid
// - error code flagged whenever the packet saw an error
// - error bit 0 is the basic error bit, upper bits extended code
// - 0001 no info, 1001 serviced but not completed
// - x101 retry later, 0011 unsupported and not serviced
// - 1011 degraded, flag tells which operation was done
// - x111 fatal, target then disconnects itself
// - each flag meaning owns its own flag bit
// - response source id is an exact copy of request source id
// - response thread id is an exact copy of request thread id
// - response packet id is an exact copy of request packet id
// - out-of-order responses only when compatibility mode is clear
module arrx_target #(
   parameter int unsigned DEPTH = arrx_pkg::DEPTH
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_cmdval,
   output logic o_cmdack,
   input wire arrx_pkg::arrx_req_s i_req,
   input wire logic i_compat_mode,
   input wire logic i_busy,
   input wire logic i_fault,
   input wire logic i_lock_clear,
   output logic o_rspval,
   input wire logic i_rspack,
   output arrx_pkg::arrx_rsp_s o_rsp,
   output logic o_disconnected
);
   localparam int unsigned IW = $clog2(DEPTH);

   // ------------------------------------------------------------
   // pending table
   // ------------------------------------------------------------
   arrx_pkg::arrx_rsp_s slot_r [DEPTH];
   logic [DEPTH-1:0] used_r;
   logic [IW-1:0] wr_ptr_r;
   logic [IW-1:0] rd_ptr_r;
   logic [IW:0] cnt_r;
   logic rspval_r;
   arrx_pkg::arrx_rsp_s rsp_r;
   logic disc_r;
   logic lock_held_r;
   logic [arrx_pkg::SRC_W-1:0] lock_src_r;
   logic [arrx_pkg::DATA_W-1:0] mem_r [DEPTH];

   logic take;
   logic issue;
   logic ooo_pop;
   logic store;
   logic [IW-1:0] put;
   logic [IW-1:0] pick;
   logic [arrx_pkg::ADDR_W-1:0] eff_addr;
   logic [arrx_pkg::ADDR_W-1:0] wrap_mask;
   logic [3:0] code;
   logic [arrx_pkg::FLAG_W-1:0] flags;
   logic locked_out;
   arrx_pkg::arrx_rsp_s new_rsp;

   // a free slot is needed; refusal is back-pressure on the command
   assign take = i_cmdval && o_cmdack;
   assign o_cmdack = (cnt_r != (IW+1)'(DEPTH)) && !disc_r;
   assign o_rspval = rspval_r;
   assign o_rsp = rsp_r;
   assign o_disconnected = disc_r;

   // ------------------------------------------------------------
   // address generation
   // ------------------------------------------------------------
   always_comb begin
      wrap_mask = '1;
      if (i_req.wrap && i_req.wrplen_en) begin
         wrap_mask = (arrx_pkg::ADDR_W'(1) << i_req.wrplen) - 1'b1;
      end
      eff_addr = i_req.addr & wrap_mask;
      if (i_req.defd) begin
         // single stride pattern, derived from start address and folded by the same wrap mask
         eff_addr = (i_req.addr + arrx_pkg::DEFD_STRIDE) & wrap_mask;
      end
   end

   // ------------------------------------------------------------
   // status coding
   // ------------------------------------------------------------
   assign locked_out = lock_held_r && (lock_src_r != i_req.srcid);

   always_comb begin
      code = arrx_pkg::ERR_OK;
      flags = '0;
      if (i_fault) begin
         code = arrx_pkg::ERR_FATAL;
      end else if (locked_out || i_busy) begin
         code = arrx_pkg::ERR_RETRY;
      end else if (i_req.cmd == arrx_pkg::CMD_NOP) begin
         code = arrx_pkg::ERR_UNSUPP;
      end else if (i_req.defd && i_req.cmd == arrx_pkg::CMD_LOCKRD) begin
         // no locked pattern transfers: answered as a degraded read, but the lock is still taken
         code = arrx_pkg::ERR_DEGRADED;
         flags[arrx_pkg::FLAG_DEGR_RD] = 1'b1;
      end else if (i_req.wrap && i_req.wrplen_en && i_req.be == '0) begin
         code = arrx_pkg::ERR_INCOMPLETE;
      end else if (i_req.wrplen_en && !i_req.wrap) begin
         code = arrx_pkg::ERR_NOINFO;
      end
   end

   always_comb begin
      new_rsp = '0;
      new_rsp.rerror = code;
      new_rsp.rflag = flags;
      new_rsp.rsrcid = i_req.srcid;
      new_rsp.rtrdid = i_req.trdid;
      new_rsp.rpktid = i_req.pktid;
      new_rsp.raddr = eff_addr;
   end

   // ------------------------------------------------------------
   // storage, one word per slot
   // ------------------------------------------------------------
   // fields sampled on the command handshake only
   always_ff @(posedge i_mclk) begin
      if (take) begin
         slot_r[put] <= new_rsp;
      end
   end

   // only clean writes land; refused or degraded ones leave memory alone
   assign store = take && (i_req.cmd == arrx_pkg::CMD_WRITE) && (code == arrx_pkg::ERR_OK);

   // cleared on reset so an unwritten word reads as zeros, never unknown
   for (genvar g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge i_mclk) begin
         if (i_rst) begin
            mem_r[g] <= '0;
         end else if (store && (eff_addr[IW+1:2] == IW'(g))) begin
            mem_r[g] <= i_req.wdata;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         lock_held_r <= 1'b0;
         lock_src_r <= '0;
      end else if (i_lock_clear) begin
         lock_held_r <= 1'b0;
      end else if (take && i_req.cmd == arrx_pkg::CMD_LOCKRD && !locked_out) begin
         lock_held_r <= 1'b1;
         lock_src_r <= i_req.srcid;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         disc_r <= 1'b0;
      end else if (take && code == arrx_pkg::ERR_FATAL) begin
         disc_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // response issue
   // ------------------------------------------------------------
   // out-of-order: newest pending slot jumps ahead; fifo in compat mode
   always_comb begin
      pick = rd_ptr_r;
      if (!i_compat_mode && cnt_r > 1) begin
         pick = wr_ptr_r - 1'b1;
      end
   end

   assign issue = (!rspval_r || i_rspack) && used_r[pick];
   // newest slot leaving ahead of the oldest leaves a hole at the top
   assign ooo_pop = issue && (pick != rd_ptr_r);
   // a take in that same cycle fills the hole, keeping the table contiguous
   assign put = ooo_pop ? pick : wr_ptr_r;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rspval_r <= 1'b0;
         rsp_r <= '0;
      end else if (issue) begin
         rspval_r <= 1'b1;
         rsp_r <= slot_r[pick];
         rsp_r.rdata <= mem_r[slot_r[pick].raddr[IW+1:2]];
      end else if (i_rspack) begin
         rspval_r <= 1'b0;
      end
      // no else update: fields hold while waiting for acceptance
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         used_r <= '0;
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (issue) begin
            used_r[pick] <= 1'b0;
            if (!ooo_pop) begin
               rd_ptr_r <= rd_ptr_r + 1'b1;
            end
         end
         // set after the clear: a refilled hole must stay marked
         if (take) begin
            used_r[put] <= 1'b1;
         end
         if (take && !ooo_pop) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end else if (!take && ooo_pop) begin
            wr_ptr_r <= wr_ptr_r - 1'b1;
         end
         cnt_r <= cnt_r + (IW+1)'(take) - (IW+1)'(issue);
      end
   end
   // all strobes above are active high
   // no early arbitration address port on this target
endmodule

// ---- tb/arrx_init_model.sv ----
`timescale 1ns/1ps
module arrx_init_model (
   input wire logic i_mclk,
   input wire logic i_cmdack,
   input wire logic i_rspval,
   output logic o_cmdval,
   output arrx_pkg::arrx_req_s o_req,
   output logic o_rspack
);
   logic stall = 1'b0;
   initial o_cmdval = 1'b0;
   initial o_req = '0;
   // accept only what is offered; stall on demand
   assign o_rspack = i_rspval && !stall;
   // nothing drives an early arbitration address toward the target
   // fields move with valid and hold to the accepting edge
   task send(input arrx_pkg::arrx_req_s r);
      o_cmdval = 1'b1;
      o_req = r;
      for (int n = 0; n < 50 && !i_cmdack; n++) begin
         @(posedge i_mclk);
         #1;
      end
      @(posedge i_mclk);
      #1;
   endtask
   // released fields turn to garbage, never the old value
   task idle();
      o_cmdval = 1'b0;
      o_req = ~o_req;
   endtask
endmodule

// ---- tb/arrx_target_chk.sv ----
`timescale 1ns/1ps
module arrx_target_chk #(
   parameter int unsigned DEPTH = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_cmdval,
   input wire logic o_cmdack,
   input wire arrx_pkg::arrx_req_s i_req,
   input wire logic i_compat_mode,
   input wire logic i_busy,
   input wire logic i_fault,
   input wire logic i_lock_clear,
   input wire logic o_rspval,
   input wire logic i_rspack,
   input wire arrx_pkg::arrx_rsp_s o_rsp,
   input wire logic o_disconnected
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   logic fresh;
   logic prev_take;
   // a lone take with nothing pending shows its response two edges later
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         prev_take <= 1'b0;
      end else begin
         prev_take <= i_cmdval && o_cmdack;
      end
   end
   assign fresh = i_cmdval && o_cmdack && !o_rspval && !prev_take;
   hold_rsp_a: assert property (o_rspval && !i_rspack |=> o_rspval && $stable(o_rsp))
      else $error("response moved before acceptance");
   answer_a: assert property (fresh |=> ##1 o_rspval)
      else $error("no response after take");
   src_copy_a: assert property (fresh |=> ##1 o_rsp.rsrcid == $past(i_req.srcid, 2))
      else $error("source id not copied");
   trd_copy_a: assert property (fresh |=> ##1 o_rsp.rtrdid == $past(i_req.trdid, 2))
      else $error("thread id not copied");
   pkt_copy_a: assert property (fresh |=> ##1 o_rsp.rpktid == $past(i_req.pktid, 2))
      else $error("packet id not copied");
   fatal_code_a: assert property (fresh && i_fault |=> o_disconnected ##1 o_rsp.rerror == 4'h7)
      else $error("fatal code or disconnect missing");
   retry_code_a: assert property (fresh && i_busy && !i_fault |=> ##1 o_rsp.rerror == 4'h5)
      else $error("busy take not retried");
   err_bit0_a: assert property (o_rspval |-> o_rsp.rerror[0] == (o_rsp.rerror != 4'h0))
      else $error("error bit 0 disagrees with code");
   gone_stays_a: assert property (o_disconnected |-> !o_cmdack ##1 o_disconnected)
      else $error("disconnected target accepts");
   cover property (fresh);
   cover property (o_rspval && !i_rspack);
   cover property (fresh && i_fault);
endmodule
bind arrx_target arrx_target_chk #(.DEPTH(DEPTH)) chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_cmdval(i_cmdval), .o_cmdack(o_cmdack), .i_req(i_req), .i_compat_mode(i_compat_mode),
   .i_busy(i_busy), .i_fault(i_fault), .i_lock_clear(i_lock_clear), .o_rspval(o_rspval),
   .i_rspack(i_rspack), .o_rsp(o_rsp), .o_disconnected(o_disconnected));

// ---- tb/tb_arrx_target.sv ----
`timescale 1ns/1ps
module tb_arrx_target;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic cmp = 1'b0;
   logic busy = 1'b0;
   logic fault = 1'b0;
   logic lclr = 1'b0;
   logic cmdval, cmdack, rspval, rspack, disc;
   arrx_pkg::arrx_req_s req;
   arrx_pkg::arrx_rsp_s rsp, s;
   arrx_pkg::arrx_req_s rq;
   int fails = 0;
   int checked = 0;
   logic [3:0] codes [5] = '{4'h5, 4'h3, 4'hB, 4'h9, 4'h1};
   initial forever #2.5 i_mclk = ~i_mclk;
   arrx_target uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cmdval(cmdval), .o_cmdack(cmdack),
      .i_req(req), .i_compat_mode(cmp), .i_busy(busy), .i_fault(fault), .i_lock_clear(lclr),
      .o_rspval(rspval), .i_rspack(rspack), .o_rsp(rsp), .o_disconnected(disc));
   arrx_init_model mdl (.i_mclk(i_mclk), .i_cmdack(cmdack), .i_rspval(rspval),
      .o_cmdval(cmdval), .o_req(req), .o_rspack(rspack));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait, then one accepted response cell
   task get();
      for (int n = 0; n < 50 && !rspval; n++) begin
         @(posedge i_mclk);
         #1;
      end
      s = rsp;
      chk(rspval, 1'b1);
      @(posedge i_mclk);
      #1;
   endtask
   function automatic arrx_pkg::arrx_req_s mk(input logic [1:0] c, input logic [7:0] p);
      mk = '0;
      mk.cmd = c;
      mk.addr = 32'h0000_1234;
      mk.be = 4'hF;
      mk.srcid = 5'h0A;
      mk.trdid = 4'h3;
      mk.pktid = p;
   endfunction
   task t_ids();
      mdl.send(mk(arrx_pkg::CMD_READ, 8'h5A));
      mdl.idle();
      get();
      chk(s.rsrcid, 5'h0A);
      chk(s.rtrdid, 4'h3);
      chk(s.rpktid, 8'h5A);
      chk(s.rerror, 4'h0);
   endtask
   task t_codes();
      for (int i = 0; i < 5; i++) begin
         rq = mk(i == 1 ? arrx_pkg::CMD_NOP : arrx_pkg::CMD_READ, 8'(i));
         busy = (i == 0);
         if (i == 2) rq.cmd = arrx_pkg::CMD_LOCKRD;
         rq.defd = (i == 2);
         rq.wrap = (i == 3);
         rq.wrplen_en = (i > 2);
         if (i == 3) rq.be = 4'h0;
         mdl.send(rq);
         mdl.idle();
         get();
         busy = 1'b0;
         chk(s.rerror, codes[i]);
         chk(s.rflag, (i == 2) ? 4'h1 : 4'h0);
      end
   endtask
   // lock taken above by source 0A shuts out source 0B until cleared
   task t_lock();
      rq = mk(arrx_pkg::CMD_READ, 8'h41);
      rq.srcid = 5'h0B;
      mdl.send(rq);
      mdl.idle();
      get();
      chk(s.rerror, 4'h5);
      lclr = 1'b1;
      @(posedge i_mclk);
      #1;
      lclr = 1'b0;
      mdl.send(rq);
      mdl.idle();
      get();
      chk(s.rerror, 4'h0);
      chk(s.rsrcid, 5'h0B);
   endtask
   // a write lands; plain and pattern reads of that word return it
   task t_data();
      rq = mk(arrx_pkg::CMD_WRITE, 8'h31);
      rq.wdata = 32'hCAFE_F00D;
      mdl.send(rq);
      mdl.idle();
      get();
      chk(s.rerror, 4'h0);
      mdl.send(mk(arrx_pkg::CMD_READ, 8'h32));
      mdl.idle();
      get();
      chk(s.rdata, 32'hCAFE_F00D);
      rq = mk(arrx_pkg::CMD_READ, 8'h33);
      rq.defd = 1'b1;
      mdl.send(rq);
      mdl.idle();
      get();
      chk(s.raddr, 32'h0000_1234 + arrx_pkg::DEFD_STRIDE);
      chk(s.rdata, 32'hCAFE_F00D);
   endtask
   task t_wrap();
      for (int w = 0; w < 5; w += 4) begin
         rq = mk(arrx_pkg::CMD_READ, 8'h20);
         rq.wrap = 1'b1;
         rq.wrplen_en = 1'b1;
         rq.wrplen = 5'(w);
         mdl.send(rq);
         mdl.idle();
         get();
         chk(s.raddr, 32'h0000_1234 & ((32'h1 << w) - 1));
      end
   endtask
   // three queued while stalled: oldest already presented
   task t_order(input logic c);
      cmp = c;
      mdl.stall = 1'b1;
      for (int p = 1; p < 4; p++) mdl.send(mk(arrx_pkg::CMD_READ, 8'(p)));
      mdl.idle();
      mdl.stall = 1'b0;
      for (int k = 0; k < 3; k++) begin
         get();
         chk(s.rpktid, (k == 0 || c) ? 8'(k + 1) : 8'(4 - k));
      end
   endtask
   task t_fault();
      fault = 1'b1;
      mdl.send(mk(arrx_pkg::CMD_READ, 8'h77));
      mdl.idle();
      get();
      fault = 1'b0;
      chk(s.rerror, 4'h7);
      chk({disc, cmdack}, 2'b10);
   endtask
   task tally_and_finish();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      t_ids();
      t_codes();
      t_lock();
      t_data();
      t_wrap();
      t_order(1'b0);
      t_order(1'b1);
      t_fault();
      tally_and_finish();
   end
endmodule
